/* design/asp_fifo.sv */
`timescale 1ns/1ps
module asp_fifo #(
   parameter int W = asp_pkg::ASP_FIFO_W,
   parameter int D = asp_pkg::ASP_FIFO_D
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   // Fill side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   import asp_pkg::*;
   localparam int AW = $clog2(D);
   localparam int CW = $clog2(D + 1);
   localparam logic [CW-1:0] FULL = CW'(D);

   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [CW-1:0] count, next_count;
   logic next_in_ready;
   logic push, pop;

   // Ready is registered so the top sees it straight from a flop
   always_comb
   begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
      next_count = count + CW'(push) - CW'(pop);
      next_in_ready = (next_count != FULL);
   end

   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];

   // Pointer and count registers
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b1;
      end
      else if (ce)
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         in_ready <= next_in_ready;
      end
   end

   // Storage has no reset; only written words are ever read
   always_ff @(posedge sys_clk)
   begin
      if (ce && push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   a_fifo_full_ready: assert property (@(posedge sys_clk) disable iff (rst)
      (count == FULL) |-> !in_ready)
      else $error("fifo full but ready high");
endmodule

/* design/asp_pkg.sv */
// Summary of operation
// (RULE1) The port is a full-duplex asynchronous serial port offering only the 8-bit and 9-bit variable-rate modes (modes 1 and 3).
// (RULE2) A completed received byte is held in its own buffer so the next byte can already shift in.
// (RULE3) One data location takes writes into the transmit path and returns the buffered received byte on reads, and transmit data is never readable.
// (RULE4) With the interrupt enabled, the interrupt rises whenever the transmit-done or receive-done flag is set.
// (RULE5) Both done flags stay set until software clears them, so software can tell which event happened.
// (RULE6) Bit timing comes from an 8-bit auto-reload timer whose visible low count clocks the transmitter.
// (RULE7) The receiver uses a hidden copy of the low count that runs while the timer runs and reloads from the same value.
// (RULE8) Overflows of both counters are divided by two to give the transmit and receive bit rates.
// (RULE9) A detected start condition forces a reload of the hidden receive counter, independent of transmit timing.
// (RULE10) Overflow rate is the timer clock divided by 256 minus the reload value, and the bit rate is half of that.
// (RULE11) Software should use the auto-reload mode and pick a reload value giving overflows at twice the bit rate.
// (RULE12) The timer clock is selectable from the system clock divided by 4, 12 or 48, the external oscillator divided by 8, or an external input pin.
// (RULE13) An 8-bit frame is a start bit, eight data bits least significant first and one stop bit, the stop bit landing in the receive ninth bit.
// (RULE14) A write to the data location starts a transmission and the transmit-done flag sets at the start of the stop bit.
// (RULE15) After the stop bit a byte is loaded and the receive flag set only if that flag is clear and, with the multiprocessor check on, the stop or ninth bit is one.
// (RULE16) A 9-bit frame carries a ninth bit from the transmit ninth-bit field, and on receive the ninth bit is kept and the stop bit ignored.
// (RULE17) Reception starts on a high-to-low edge of the idle-high line while receive is enabled, and bits are sampled near their centre.
package asp_pkg;
   // Timer clock source selection codes
   localparam logic [2:0] ASP_SEL_DIV4 = 3'h0;
   localparam logic [2:0] ASP_SEL_DIV12 = 3'h1;
   localparam logic [2:0] ASP_SEL_DIV48 = 3'h2;
   localparam logic [2:0] ASP_SEL_EXTOSC = 3'h3;
   localparam logic [2:0] ASP_SEL_EXTIN = 3'h4;
   // Prescaler terminal counts (divide minus one)
   localparam logic [5:0] ASP_PRE_DIV4 = 6'h03;
   localparam logic [5:0] ASP_PRE_DIV12 = 6'h0B;
   localparam logic [5:0] ASP_PRE_DIV48 = 6'h2F;
   localparam logic [2:0] ASP_OSC_DIV = 3'h7;
   // Timer and frame constants
   localparam logic [7:0] ASP_TMR_TOP = 8'hFF;
   localparam logic [7:0] ASP_TMR_RST = 8'h00;
   localparam logic [2:0] ASP_LAST_BIT = 3'h7;
   localparam logic ASP_LINE_IDLE = 1'b1;
   // Transmit FIFO shape
   localparam int ASP_FIFO_W = 9;
   localparam int ASP_FIFO_D = 16;

   // One timer step: overflow flag above the next count
   function automatic logic [8:0] asp_step(input logic [7:0] cnt, input logic [7:0] rld);
      if (cnt == ASP_TMR_TOP)
      begin
         return {1'b1, rld};
      end
      return {1'b0, cnt + 8'h01};
   endfunction
endpackage

/* design/asp_serial_port.sv */
`timescale 1ns/1ps
module asp_serial_port (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   // Control bits
   input wire logic frame_size_select,
   input wire logic multiproc_check_enable,
   input wire logic receive_enable_bit,
   input wire logic tx_ninth_bit,
   input wire logic irq_enable,
   input wire logic timer_run,
   input wire logic [7:0] timer_reload_value,
   input wire logic [2:0] timer_clk_sel,
   // Data location and flag clears
   input wire logic data_wr,
   input wire logic [7:0] data_wr_byte,
   output logic data_wr_ready,
   input wire logic tx_done_clr,
   input wire logic rx_done_clr,
   // Status
   output logic [7:0] serial_data_buffer,
   output logic rx_ninth_bit,
   output logic tx_done_flag,
   output logic rx_done_flag,
   output logic port_irq,
   output logic [7:0] timer_low_count,
   // Pins
   input wire logic ext_osc_pin,
   input wire logic timer_external_input,
   input wire logic rxd_pin,
   output logic txd_pin
);
   import asp_pkg::*;

   typedef enum logic [4:0] {ST_IDLE = 5'h01, ST_START = 5'h02, ST_DATA = 5'h04,
      ST_NINTH = 5'h08, ST_STOP = 5'h10} asp_state_e;

   // Pin synchronisers; third stage only feeds edge detection
   logic osc_s1, osc_s2, osc_s3, ext_s1, ext_s2, ext_s3, rx_s1, rx_s2, rx_s3;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         {osc_s1, osc_s2, osc_s3} <= 3'h0;
         {ext_s1, ext_s2, ext_s3} <= 3'h0;
         {rx_s1, rx_s2, rx_s3} <= 3'h7;
      end
      else if (ce)
      begin
         {osc_s1, osc_s2, osc_s3} <= {ext_osc_pin, osc_s1, osc_s2};
         {ext_s1, ext_s2, ext_s3} <= {timer_external_input, ext_s1, ext_s2};
         {rx_s1, rx_s2, rx_s3} <= {rxd_pin, rx_s1, rx_s2};
      end
   end

   // Timer clock tick generation
   logic [5:0] pre_cnt, next_pre_cnt;
   logic [2:0] osc_cnt, next_osc_cnt;
   logic tick, next_tick;
   logic [5:0] pre_lim;
   logic osc_edge;
   always_comb
   begin
      unique case (timer_clk_sel) // see (RULE12)
         ASP_SEL_DIV12: pre_lim = ASP_PRE_DIV12;
         ASP_SEL_DIV48: pre_lim = ASP_PRE_DIV48;
         default: pre_lim = ASP_PRE_DIV4;
      endcase
      next_pre_cnt = (pre_cnt >= pre_lim) ? 6'h00 : pre_cnt + 6'h01;
      osc_edge = osc_s2 && !osc_s3;
      next_osc_cnt = osc_edge ? osc_cnt + 3'h1 : osc_cnt;
      unique case (timer_clk_sel)
         ASP_SEL_EXTOSC: next_tick = osc_edge && (osc_cnt == ASP_OSC_DIV);
         ASP_SEL_EXTIN: next_tick = !ext_s2 && ext_s3;
         default: next_tick = (pre_cnt >= pre_lim);
      endcase
      next_tick = next_tick && timer_run;
   end
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         pre_cnt <= 6'h00;
         osc_cnt <= 3'h0;
         tick <= 1'b0;
      end
      else if (ce)
      begin
         pre_cnt <= next_pre_cnt;
         osc_cnt <= next_osc_cnt;
         tick <= next_tick;
      end
   end

   // Visible low count for transmit, hidden copy for receive
   logic [7:0] rx_cnt, next_rx_cnt, next_tx_cnt;
   logic tx_ovf, next_tx_ovf, rx_ovf, next_rx_ovf;
   logic tx_half, next_tx_half, rx_half, next_rx_half;
   logic start_det, tx_baud, rx_sample;
   asp_state_e rx_state, next_rx_state;
   always_comb
   begin
      start_det = (rx_state == ST_IDLE) && receive_enable_bit && rx_s3 && !rx_s2; // see (RULE17)
      {next_tx_ovf, next_tx_cnt} = {1'b0, timer_low_count};
      {next_rx_ovf, next_rx_cnt} = {1'b0, rx_cnt};
      if (tick)
      begin
         {next_tx_ovf, next_tx_cnt} = asp_step(timer_low_count, timer_reload_value); // see (RULE6)
         {next_rx_ovf, next_rx_cnt} = asp_step(rx_cnt, timer_reload_value); // see (RULE7) (RULE10)
      end
      next_tx_half = tx_ovf ? !tx_half : tx_half; // see (RULE8)
      next_rx_half = rx_ovf ? !rx_half : rx_half; // see (RULE8)
      // Start edge restarts receive timing half a bit ahead of the centre
      if (start_det)
      begin
         next_rx_cnt = timer_reload_value; // see (RULE9)
         next_rx_ovf = 1'b0;
         next_rx_half = 1'b0;
      end
      tx_baud = tx_ovf && tx_half;
      rx_sample = rx_ovf && !rx_half; // see (RULE17)
   end
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         timer_low_count <= ASP_TMR_RST;
         rx_cnt <= ASP_TMR_RST;
         tx_ovf <= 1'b0;
         rx_ovf <= 1'b0;
         tx_half <= 1'b0;
         rx_half <= 1'b0;
      end
      else if (ce)
      begin
         timer_low_count <= next_tx_cnt;
         rx_cnt <= next_rx_cnt;
         tx_ovf <= next_tx_ovf;
         rx_ovf <= next_rx_ovf;
         tx_half <= next_tx_half;
         rx_half <= next_rx_half;
      end
   end

   // Transmit holding FIFO between the data location and the shifter
   logic fifo_valid, tx_pop;
   logic [8:0] fifo_data;
   asp_fifo #(.W(ASP_FIFO_W), .D(ASP_FIFO_D)) u_tx_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .in_valid(data_wr), // see (RULE3) (RULE14)
      .in_data({tx_ninth_bit, data_wr_byte}),
      .in_ready(data_wr_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(tx_pop)
   );

   // Transmitter; a new frame may follow the stop bit directly
   asp_state_e tx_state, next_tx_state;
   logic [8:0] tx_shift, next_tx_shift;
   logic [2:0] tx_bits, next_tx_bits;
   logic next_txd, next_tx_done;
   always_comb
   begin
      next_tx_state = tx_state;
      next_tx_shift = tx_shift;
      next_tx_bits = tx_bits;
      next_txd = txd_pin;
      tx_pop = 1'b0;
      next_tx_done = tx_done_flag && !tx_done_clr; // see (RULE5)
      if (tx_baud)
      begin
         unique case (tx_state)
            ST_IDLE, ST_STOP:
            begin
               next_txd = ASP_LINE_IDLE;
               next_tx_state = ST_IDLE;
               if (fifo_valid)
               begin
                  tx_pop = 1'b1;
                  next_tx_shift = fifo_data;
                  next_txd = 1'b0; // see (RULE13)
                  next_tx_state = ST_START;
               end
            end
            ST_START:
            begin
               next_txd = tx_shift[0]; // see (RULE13)
               next_tx_bits = 3'h0;
               next_tx_state = ST_DATA;
            end
            ST_DATA:
            begin
               next_tx_shift = {1'b0, tx_shift[8:1]};
               next_tx_bits = tx_bits + 3'h1;
               next_txd = tx_shift[1];
               if (tx_bits == ASP_LAST_BIT)
               begin
                  next_txd = frame_size_select ? tx_shift[1] : ASP_LINE_IDLE; // see (RULE16)
                  next_tx_state = frame_size_select ? ST_NINTH : ST_STOP; // see (RULE1)
                  next_tx_done = next_tx_done || !frame_size_select; // see (RULE14)
               end
            end
            ST_NINTH:
            begin
               next_txd = ASP_LINE_IDLE;
               next_tx_state = ST_STOP;
               next_tx_done = 1'b1; // see (RULE14)
            end
         endcase
      end
   end
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         tx_state <= ST_IDLE;
         tx_shift <= 9'h000;
         tx_bits <= 3'h0;
         txd_pin <= ASP_LINE_IDLE;
         tx_done_flag <= 1'b0;
      end
      else if (ce)
      begin
         tx_state <= next_tx_state;
         tx_shift <= next_tx_shift;
         tx_bits <= next_tx_bits;
         txd_pin <= next_txd;
         tx_done_flag <= next_tx_done;
      end
   end

   // Receiver; the shifter is apart from the buffer so a new byte can arrive
   logic [7:0] rx_shift, next_rx_shift, next_rx_buf;
   logic [2:0] rx_bits, next_rx_bits;
   logic rx_nin, next_rx_nin, next_rx_ninth, next_rx_done, next_irq, frame_bit;
   always_comb
   begin
      next_rx_state = rx_state;
      next_rx_shift = rx_shift;
      next_rx_bits = rx_bits;
      next_rx_nin = rx_nin;
      next_rx_buf = serial_data_buffer;
      next_rx_ninth = rx_ninth_bit;
      next_rx_done = rx_done_flag && !rx_done_clr; // see (RULE5)
      frame_bit = frame_size_select ? rx_nin : rx_s2; // see (RULE13) (RULE16)
      if (start_det)
      begin
         next_rx_state = ST_START;
      end
      else if (rx_sample)
      begin
         unique case (rx_state)
            ST_IDLE: next_rx_state = ST_IDLE;
            ST_START:
            begin
               // A glitch shorter than half a bit is dropped here
               next_rx_state = rx_s2 ? ST_IDLE : ST_DATA;
               next_rx_bits = 3'h0;
            end
            ST_DATA:
            begin
               next_rx_shift = {rx_s2, rx_shift[7:1]}; // see (RULE13)
               next_rx_bits = rx_bits + 3'h1;
               if (rx_bits == ASP_LAST_BIT)
               begin
                  next_rx_state = frame_size_select ? ST_NINTH : ST_STOP;
               end
            end
            ST_NINTH:
            begin
               next_rx_nin = rx_s2; // see (RULE16)
               next_rx_state = ST_STOP;
            end
            ST_STOP:
            begin
               next_rx_state = ST_IDLE;
               // Set wins over a clear arriving in the same cycle
               if (!rx_done_flag && (!multiproc_check_enable || frame_bit)) // see (RULE15)
               begin
                  next_rx_buf = rx_shift; // see (RULE2) (RULE3)
                  next_rx_ninth = frame_bit;
                  next_rx_done = 1'b1;
               end
            end
         endcase
      end
      next_irq = irq_enable && (next_tx_done || next_rx_done); // see (RULE4)
   end
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_state <= ST_IDLE;
         rx_shift <= 8'h00;
         rx_bits <= 3'h0;
         rx_nin <= 1'b0;
         serial_data_buffer <= 8'h00;
         rx_ninth_bit <= 1'b0;
         rx_done_flag <= 1'b0;
         port_irq <= 1'b0;
      end
      else if (ce)
      begin
         rx_state <= next_rx_state;
         rx_shift <= next_rx_shift;
         rx_bits <= next_rx_bits;
         rx_nin <= next_rx_nin;
         serial_data_buffer <= next_rx_buf;
         rx_ninth_bit <= next_rx_ninth;
         rx_done_flag <= next_rx_done;
         port_irq <= next_irq;
      end
   end

   // Checks on the timing and flag behaviour
   a_tx_flag_hold: assert property (@(posedge sys_clk) disable iff (rst) // see (RULE5)
      ce && tx_done_flag && !tx_done_clr |=> tx_done_flag) else $error("tx flag lost");
   a_irq_from_flag: assert property (@(posedge sys_clk) disable iff (rst) // see (RULE4)
      ce && irq_enable && rx_done_flag && !rx_done_clr |=> port_irq) else $error("irq missing");
   a_tx_start_low: assert property (@(posedge sys_clk) disable iff (rst) // see (RULE13)
      (tx_state == ST_START) |-> !txd_pin) else $error("start bit not low");
   a_tx_done_stop: assert property (@(posedge sys_clk) disable iff (rst) // see (RULE14)
      $rose(tx_done_flag) |-> (tx_state == ST_STOP) && txd_pin) else $error("tx done early");
   a_rx_no_overrun: assert property (@(posedge sys_clk) disable iff (rst) // see (RULE15)
      ce && rx_done_flag && !rx_done_clr |=> $stable(serial_data_buffer)) else $error("overrun");
   a_rx_reload: assert property (@(posedge sys_clk) disable iff (rst) // see (RULE9)
      ce && start_det |=> (rx_cnt == $past(timer_reload_value)) && !rx_half)
      else $error("rx counter not reloaded on start");
   a_tx_autoreload: assert property (@(posedge sys_clk) disable iff (rst) // see (RULE6)
      ce && tick && (timer_low_count == ASP_TMR_TOP) |=> tx_ovf &&
      (timer_low_count == $past(timer_reload_value))) else $error("no auto reload");
   a_baud_halved: assert property (@(posedge sys_clk) disable iff (rst) // see (RULE8)
      ce && tx_ovf |=> (tx_half != $past(tx_half))) else $error("divider stuck");
endmodule

/* test/asp_remote.sv */
`timescale 1ns/1ps
module asp_remote (
   // Clock
   input wire logic sys_clk,
   // Line pins
   input wire logic line_in,
   output logic line_out,
   // Frame shape
   input wire logic nine_mode
);
   int bit_len = 16;
   logic [8:0] rx_q[$];
   logic [9:0] w;

   // Frame out: start low, LSB first, ninth only in nine_mode, stop; line idles high
   task automatic send(input logic [7:0] d, input logic b9, input logic stop);
      logic [10:0] fr;
      fr = nine_mode ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
      for (int i = 0; i < (nine_mode ? 11 : 10); i++)
      begin
         @(posedge sys_clk);
         #1 line_out = fr[i];
         repeat (bit_len - 1) @(posedge sys_clk);
      end
      @(posedge sys_clk);
      #1 line_out = 1'b1;
   endtask

   // Low pulse far shorter than half a bit, so it must not start a frame
   task automatic glitch();
      @(posedge sys_clk);
      #1 line_out = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 line_out = 1'b1;
   endtask

   // Receiver samples at bit centres; stop or ninth bit lands in bit 8
   initial
   begin
      line_out = 1'b1;
      forever
      begin
         @(negedge line_in);
         repeat (bit_len / 2) @(posedge sys_clk);
         if (line_in === 1'b0)
         begin
            for (int i = 0; i < (nine_mode ? 10 : 9); i++)
            begin
               repeat (bit_len) @(posedge sys_clk);
               w[i] = line_in;
            end
            rx_q.push_back(w[8:0]);
         end
      end
   end
endmodule

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
   import asp_pkg::*;
   logic sys_clk, rxd_pin, txd_pin, data_wr_ready, rx_ninth_bit, port_irq;
   logic tx_done_flag, rx_done_flag;
   logic [7:0] serial_data_buffer, timer_low_count;
   logic rst = 1'b1, ce = 1'b1, frame_size_select = 1'b0, multiproc_check_enable = 1'b0;
   logic receive_enable_bit = 1'b0, tx_ninth_bit = 1'b0, irq_enable = 1'b0, timer_run = 1'b0;
   logic data_wr = 1'b0, tx_done_clr = 1'b0, rx_done_clr = 1'b0;
   logic ext_osc_pin = 1'b0, timer_external_input = 1'b0;
   logic [7:0] timer_reload_value = 8'hFE, data_wr_byte = 8'h00;
   logic [2:0] timer_clk_sel = 3'h0;
   logic [8:0] exp_q[$];
   int n_fail = 0;
   int check_count = 0;
   int k;
   int bt[5] = '{16, 48, 192, 320, 40};

   asp_serial_port i_asp_serial_port (
      .sys_clk, .rst, .ce, .frame_size_select, .multiproc_check_enable, .receive_enable_bit,
      .tx_ninth_bit, .irq_enable, .timer_run, .timer_reload_value, .timer_clk_sel, .data_wr,
      .data_wr_byte, .data_wr_ready, .tx_done_clr, .rx_done_clr, .serial_data_buffer,
      .rx_ninth_bit, .tx_done_flag, .rx_done_flag, .port_irq, .timer_low_count, .ext_osc_pin,
      .timer_external_input, .rxd_pin, .txd_pin
   );
   asp_remote i_asp_remote (
      .sys_clk, .line_in(txd_pin), .line_out(rxd_pin), .nine_mode(frame_size_select)
   );

   // 100 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Both external timer sources toggle every 5 cycles
   initial
   begin
      forever
      begin
         repeat (5) @(posedge sys_clk);
         #1 ext_osc_pin = ~ext_osc_pin;
         timer_external_input = ~timer_external_input;
      end
   end

   // Hang guard, well past the expected run length
   initial
   begin
      repeat (60000) @(posedge sys_clk);
      n_fail++;
      close_out();
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("Checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
      begin
         $display("== PASSED ==");
      end
      else
      begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Single-cycle clear pulse, 0 = transmit flag, 1 = receive flag
   task automatic clr(input bit rx);
      if (rx)
      begin
         rx_done_clr = 1'b1;
      end
      else
      begin
         tx_done_clr = 1'b1;
      end
      @(posedge sys_clk);
      #1;
      // Lower only the strobe raised here, so a following clear may start at once
      if (rx)
      begin
         rx_done_clr = 1'b0;
      end
      else
      begin
         tx_done_clr = 1'b0;
      end
   endtask

   task automatic wr(input logic [7:0] d, input logic n9);
      int j;
      j = 0;
      while (data_wr_ready !== 1'b1 && j < 1000)
      begin
         @(posedge sys_clk);
         #1 j++;
      end
      data_wr = 1'b1;
      data_wr_byte = d;
      tx_ninth_bit = n9;
      @(posedge sys_clk);
      #1 data_wr = 1'b0;
   endtask

   // Waits for 0 = line low, 1 = transmit flag, 2 = receive flag; n counts cycles waited
   task automatic wait_for(input int w, input int lim, output int n);
      n = 0;
      while (n < lim && (w == 0 ? txd_pin : w == 1 ? !tx_done_flag : !rx_done_flag) !== 1'b0)
      begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk(n < lim, 1'b1, "wait bound");
   endtask

   function automatic logic [8:0] pop_rx();
      return i_asp_remote.rx_q.size() > 0 ? i_asp_remote.rx_q.pop_front() : 9'h000;
   endfunction

   // One frame out; bit time from start edge to flag, checked against the source
   task automatic measure(input logic [2:0] s, input logic [7:0] r, input int b, input logic n9);
      int n;
      timer_clk_sel = s;
      timer_reload_value = r;
      i_asp_remote.bit_len = b;
      repeat (4 * b) @(posedge sys_clk);
      #1 clr(1'b0);
      wr(8'h5A, n9);
      wait_for(0, 12 * b, n);
      wait_for(1, 12 * b, n);
      chk(n, (frame_size_select ? 10 : 9) * b, "bit time");
      chk(txd_pin, 1'b1, "stop level");
      chk(port_irq, 1'b1, "tx irq");
      repeat (2 * b) @(posedge sys_clk);
      #1 chk(tx_done_flag, 1'b1, "tx flag held");
      chk(pop_rx(), {frame_size_select ? n9 : 1'b1, 8'h5A}, "tx frame");
   endtask

   task automatic rcv(input logic [7:0] d, input logic b9, input logic sb, input logic fl,
                      input logic [7:0] eb, input logic en);
      i_asp_remote.send(d, b9, sb);
      repeat (8) @(posedge sys_clk);
      #1 chk(rx_done_flag, fl, "rx flag");
      chk(serial_data_buffer, eb, "rx byte");
      chk(rx_ninth_bit, en, "rx ninth");
   endtask

   // Main sequence
   initial
   begin
      repeat (3) @(posedge sys_clk);
      #1 rst = 1'b0;
      chk({txd_pin, data_wr_ready, tx_done_flag, rx_done_flag, port_irq}, 5'h18, "idle");
      chk({serial_data_buffer, timer_low_count}, {8'h00, ASP_TMR_RST}, "reset bytes");
      timer_run = 1'b1;
      receive_enable_bit = 1'b1;
      irq_enable = 1'b1;
      repeat (1100) @(posedge sys_clk);
      repeat (6)
      begin
         @(posedge sys_clk);
         #1 chk(timer_low_count >= 8'hFE, 1'b1, "low count");
      end
      // Clock enable low must freeze the visible count
      k = timer_low_count;
      ce = 1'b0;
      repeat (8) @(posedge sys_clk);
      #1 chk(timer_low_count, k[7:0], "frozen count");
      ce = 1'b1;
      for (int s = 0; s < 5; s++)
      begin
         measure(s[2:0], 8'hFE, bt[s], 1'b0);
      end
      measure(ASP_SEL_DIV4, 8'hFD, 24, 1'b0);
      measure(3'h5, 8'hFE, 16, 1'b0);
      frame_size_select = 1'b1;
      measure(ASP_SEL_DIV4, 8'hFE, 16, 1'b1);
      measure(ASP_SEL_DIV4, 8'hFE, 16, 1'b0);
      frame_size_select = 1'b0;
      // Fill until refused, then drain gap-free; the refused byte must not appear
      clr(1'b0);
      for (int i = 0; i < 40; i++)
      begin
         data_wr = 1'b1;
         data_wr_byte = 8'h20 + 8'(i);
         if (data_wr_ready !== 1'b1)
         begin
            break;
         end
         exp_q.push_back({1'b1, data_wr_byte});
         @(posedge sys_clk);
         #1;
      end
      @(posedge sys_clk);
      #1 data_wr = 1'b0;
      chk(exp_q.size() >= 16, 1'b1, "fifo depth");
      k = 0;
      while (i_asp_remote.rx_q.size() < exp_q.size() && k < 8000)
      begin
         @(posedge sys_clk);
         #1 k++;
      end
      repeat (400) @(posedge sys_clk);
      #1 chk(i_asp_remote.rx_q.size(), exp_q.size(), "frame count");
      while (exp_q.size() > 0)
      begin
         chk(pop_rx(), exp_q.pop_front(), "fifo order");
      end
      chk(data_wr_ready, 1'b1, "drained");
      // Receive: overrun, multiprocessor gating, both frame sizes
      clr(1'b0);
      clr(1'b1);
      rcv(8'h3C, 1'b0, 1'b1, 1'b1, 8'h3C, 1'b1);
      chk(port_irq, 1'b1, "rx irq");
      irq_enable = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 chk(port_irq, 1'b0, "irq masked");
      irq_enable = 1'b1;
      rcv(8'hA1, 1'b0, 1'b1, 1'b1, 8'h3C, 1'b1);
      clr(1'b1);
      multiproc_check_enable = 1'b1;
      rcv(8'h55, 1'b0, 1'b0, 1'b0, 8'h3C, 1'b1);
      rcv(8'h55, 1'b0, 1'b1, 1'b1, 8'h55, 1'b1);
      clr(1'b1);
      frame_size_select = 1'b1;
      rcv(8'h66, 1'b0, 1'b1, 1'b0, 8'h55, 1'b1);
      rcv(8'h66, 1'b1, 1'b1, 1'b1, 8'h66, 1'b1);
      clr(1'b1);
      multiproc_check_enable = 1'b0;
      rcv(8'h77, 1'b0, 1'b0, 1'b1, 8'h77, 1'b0);
      clr(1'b1);
      frame_size_select = 1'b0;
      receive_enable_bit = 1'b0;
      rcv(8'h12, 1'b0, 1'b1, 1'b0, 8'h77, 1'b0);
      receive_enable_bit = 1'b1;
      i_asp_remote.glitch();
      repeat (320) @(posedge sys_clk);
      #1 chk(rx_done_flag, 1'b0, "glitch");
      // Two frames back to back while transmitting; read the first before the second starts
      fork
         begin
            i_asp_remote.send(8'h81, 1'b0, 1'b1);
            i_asp_remote.send(8'h42, 1'b0, 1'b1);
         end
         begin
            wait_for(2, 400, k);
            chk(serial_data_buffer, 8'h81, "first byte");
            clr(1'b1);
         end
         wr(8'h99, 1'b0);
      join
      repeat (8) @(posedge sys_clk);
      #1 chk(serial_data_buffer, 8'h42, "second byte");
      chk(pop_rx(), {1'b1, 8'h99}, "duplex tx");
      close_out();
   end
endmodule
